/* File: hw/eqc_pkg.sv */
// package of the encoder counter register set: offsets, fields, modes
// assumes a 32-bit APB with byte addresses in the low eight bits
package eqc_pkg;
  localparam int ADDR_W = 8;
  typedef logic [ADDR_W-1:0] eqc_addr_t;
  typedef logic [15:0] eqc_word_t;

  // register byte offsets
  localparam eqc_addr_t OFS_CTRL = 8'h00;
  localparam eqc_addr_t OFS_STATUS = 8'h04;
  localparam eqc_addr_t OFS_IRQ_CLR = 8'h08;
  localparam eqc_addr_t OFS_IRQ_EN = 8'h0C;
  localparam eqc_addr_t OFS_POS_H = 8'h10;
  localparam eqc_addr_t OFS_POS_L = 8'h14;
  localparam eqc_addr_t OFS_POS_HLD = 8'h18;
  localparam eqc_addr_t OFS_VEL = 8'h1C;
  localparam eqc_addr_t OFS_IDX_H = 8'h20;
  localparam eqc_addr_t OFS_IDX_L = 8'h24;
  localparam eqc_addr_t OFS_IDX_HLD = 8'h28;
  localparam eqc_addr_t OFS_IC_H = 8'h2C;
  localparam eqc_addr_t OFS_IC_L = 8'h30;
  localparam eqc_addr_t OFS_LE_H = 8'h34;
  localparam eqc_addr_t OFS_LE_L = 8'h38;
  localparam eqc_addr_t OFS_GE_H = 8'h3C;
  localparam eqc_addr_t OFS_GE_L = 8'h40;
  localparam eqc_addr_t OFS_TMR_H = 8'h44;
  localparam eqc_addr_t OFS_TMR_L = 8'h48;
  localparam eqc_addr_t OFS_THLD_H = 8'h4C;
  localparam eqc_addr_t OFS_THLD_L = 8'h50;

  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CAP_BIT = 3;
  // status / enable / clear layout
  localparam int EN_IDX_BIT = 0;
  localparam int ST_IDX_BIT = 1;
  localparam int EN_RE_BIT = 6;
  localparam int ST_RE_BIT = 7;

  // reset values
  localparam eqc_word_t WORD_RST = 16'h0000;
  localparam logic [31:0] DWORD_RST = 32'h0000_0000;

  // position_init_mode encodings
  typedef enum logic [2:0] {
    PIM_NONE = 3'h0,
    PIM_EVERY_IDX = 3'h1,
    PIM_NEXT_IDX_ZERO = 3'h2,
    PIM_FIRST_IDX_LOAD = 3'h3,
    PIM_SECOND_IDX_LOAD = 3'h4,
    PIM_MODULO = 3'h5
  } eqc_pim_e;

  // home/index tracking, gray along idle -> armed -> second
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_ARMED = 2'b01,
    HS_SECOND = 2'b11
  } eqc_home_e;
endpackage : eqc_pkg

/* File: hw/eqc_rise.sv */
// rising edge detector for a synchronous event input
// assumes the input is already synchronous to the clock
`timescale 1ns/1ps
module eqc_rise (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_lvl,
  output logic o_rise
);
  import eqc_pkg::*;
  logic lvl_q;

  // previous level, cleared by reset so a high input after reset counts as an edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= i_lvl;
    end
  end

  assign o_rise = i_lvl & ~lvl_q;
endmodule : eqc_rise

/* File: hw/eqc_cnt32.sv */
// 32-bit up/down counter with a load port that wins over counting
// assumes up and down are single-cycle pulses
`timescale 1ns/1ps
module eqc_cnt32 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [31:0] i_load_val,
  input wire logic i_up,
  input wire logic i_dn,
  output logic [31:0] o_cnt
);
  import eqc_pkg::*;

  // software or init load first; up and down together cancel
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cnt <= DWORD_RST;
    end else if (i_load) begin
      o_cnt <= i_load_val;
    end else if (i_up && !i_dn) begin
      o_cnt <= o_cnt + 32'h0000_0001;
    end else if (i_dn && !i_up) begin
      o_cnt <= o_cnt - 32'h0000_0001;
    end
  end
endmodule : eqc_cnt32

/* File: hw/eqc_regs.sv */
// encoder counter register set: counters, hold registers, compare and index flags
// assumes count pulses come from an external decoder, all inputs synchronous to I_CLK
//
// Summary of operation
// - index event sets the index-event flag; flag is zero without events
// - index interrupt is raised only while its enable bit is one
// - reinit-complete flag is set only in init modes 011 and 100
// - 32-bit position counter reached as high and low 16-bit words
// - 16-bit position hold register carries the position high word
// - 16-bit velocity counter, read and written as one word
// - 32-bit index counter reached as high and low 16-bit words
// - 16-bit index hold register carries the index counter high word
// - 32-bit init/capture value: preload for and capture of position
// - 32-bit less-or-equal compare value in two 16-bit words
// - 32-bit greater-or-equal compare value in two 16-bit words
// - 32-bit interval timer reached as high and low 16-bit words
// - 32-bit interval hold register split into high and low words
`timescale 1ns/1ps
module eqc_regs (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire eqc_pkg::eqc_addr_t I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_POS_UP,
  input wire logic I_POS_DN,
  input wire logic I_INDEX,
  input wire logic I_HOME,
  input wire logic I_TMR_TICK,
  output logic O_IRQ,
  output logic O_LE_MATCH,
  output logic O_GE_MATCH
);
  import eqc_pkg::*;

  // address map check, used by decode and error answer
  function automatic logic map_ok(input eqc_addr_t a);
    map_ok = (a[1:0] == 2'b00) && (a <= OFS_THLD_L);
  endfunction : map_ok

  // new 32-bit value with one half replaced
  function automatic logic [31:0] put_half(input logic [31:0] old, input logic hi,
                                            input eqc_word_t w);
    put_half = hi ? {w, old[15:0]} : {old[31:16], w};
  endfunction : put_half

  logic wr_acc, rd_set;
  logic [31:0] rd_word;
  logic [31:0] prdata_q;
  logic [2:0] mode_q;
  logic cap_en_q;
  logic st_idx_q, st_re_q, en_idx_q, en_re_q;
  logic [31:0] pos_cnt, idx_cnt, tmr_cnt;
  eqc_word_t pos_hold_q, idx_hold_q, vel_q;
  logic [31:0] ic_q, le_q, ge_q, thld_q;
  logic evt_idx, evt_home;
  logic dir_dn_q;
  eqc_home_e home_q;
  logic init_act, init_load;
  logic pos_load, idx_load, tmr_load;
  logic [31:0] pos_load_val, idx_load_val, tmr_load_val;
  logic le_q_out, ge_q_out;
  eqc_word_t wlo;

  // writes take effect at the access edge, reads sample at the setup edge
  assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & map_ok(I_PADDR);
  assign rd_set = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign wlo = I_PWDATA[15:0];
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~map_ok(I_PADDR);
  assign O_PRDATA = prdata_q;

  // input edges from the encoder side
  eqc_rise u_idx_rise (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_lvl(I_INDEX),
    .o_rise(evt_idx)
  );
  eqc_rise u_home_rise (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_lvl(I_HOME),
    .o_rise(evt_home)
  );

  // read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_word = DWORD_RST;
    case (I_PADDR)
      OFS_CTRL: rd_word = {28'h000_0000, cap_en_q, mode_q};
      OFS_STATUS, OFS_IRQ_EN: begin
        rd_word[ST_IDX_BIT] = (I_PADDR == OFS_STATUS) & st_idx_q;
        rd_word[ST_RE_BIT] = (I_PADDR == OFS_STATUS) & st_re_q;
        rd_word[EN_IDX_BIT] = en_idx_q;
        rd_word[EN_RE_BIT] = en_re_q;
      end
      OFS_POS_H: rd_word = {16'h0000, pos_cnt[31:16]};
      OFS_POS_L: rd_word = {16'h0000, pos_cnt[15:0]};
      OFS_POS_HLD: rd_word = {16'h0000, pos_hold_q};
      OFS_VEL: rd_word = {16'h0000, vel_q};
      OFS_IDX_H: rd_word = {16'h0000, idx_cnt[31:16]};
      OFS_IDX_L: rd_word = {16'h0000, idx_cnt[15:0]};
      OFS_IDX_HLD: rd_word = {16'h0000, idx_hold_q};
      OFS_IC_H: rd_word = {16'h0000, ic_q[31:16]};
      OFS_IC_L: rd_word = {16'h0000, ic_q[15:0]};
      OFS_LE_H: rd_word = {16'h0000, le_q[31:16]};
      OFS_LE_L: rd_word = {16'h0000, le_q[15:0]};
      OFS_GE_H: rd_word = {16'h0000, ge_q[31:16]};
      OFS_GE_L: rd_word = {16'h0000, ge_q[15:0]};
      OFS_TMR_H: rd_word = {16'h0000, tmr_cnt[31:16]};
      OFS_TMR_L: rd_word = {16'h0000, tmr_cnt[15:0]};
      OFS_THLD_H: rd_word = {16'h0000, thld_q[31:16]};
      OFS_THLD_L: rd_word = {16'h0000, thld_q[15:0]};
      default: rd_word = DWORD_RST;
    endcase
  end

  // read data is registered so the access cycle sees a flop output
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      prdata_q <= DWORD_RST;
    end else if (rd_set) begin
      prdata_q <= rd_word;
    end
  end

  // control register: init mode and capture-on-home enable
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      mode_q <= PIM_NONE;
      cap_en_q <= 1'b0;
    end else if (wr_acc && I_PADDR == OFS_CTRL) begin
      mode_q <= I_PWDATA[CTRL_MODE_LSB +: 3];
      cap_en_q <= I_PWDATA[CTRL_CAP_BIT];
    end
  end

  // home/index sequencing for the index-driven init modes
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      home_q <= HS_IDLE;
    end else if (evt_home) begin
      home_q <= HS_ARMED;
    end else if (evt_idx) begin
      case (home_q)
        HS_ARMED: home_q <= (mode_q == PIM_SECOND_IDX_LOAD) ? HS_SECOND : HS_IDLE;
        HS_SECOND: home_q <= HS_IDLE;
        default: home_q <= HS_IDLE;
      endcase
    end
  end

  // init action: index resets or preloads position depending on mode
  always_comb begin
    init_act = 1'b0;
    init_load = 1'b0;
    case (mode_q)
      PIM_EVERY_IDX: init_act = evt_idx;
      PIM_NEXT_IDX_ZERO: init_act = evt_idx & (home_q == HS_ARMED);
      PIM_FIRST_IDX_LOAD: begin
        init_act = evt_idx & (home_q == HS_ARMED);
        init_load = 1'b1;
      end
      PIM_SECOND_IDX_LOAD: begin
        init_act = evt_idx & (home_q == HS_SECOND);
        init_load = 1'b1;
      end
      default: init_act = 1'b0;
    endcase
  end

  // position counter: software write, then init action, then counting
  always_comb begin
    pos_load = 1'b0;
    pos_load_val = pos_cnt;
    if (wr_acc && I_PADDR == OFS_POS_L) begin
      pos_load = 1'b1;
      pos_load_val = {pos_hold_q, wlo};
    end else if (wr_acc && I_PADDR == OFS_POS_H) begin
      pos_load = 1'b1;
      pos_load_val = put_half(pos_cnt, 1'b1, wlo);
    end else if (init_act) begin
      pos_load = 1'b1;
      pos_load_val = init_load ? ic_q : DWORD_RST;
    end
  end

  eqc_cnt32 u_pos (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_load(pos_load),
    .i_load_val(pos_load_val),
    .i_up(I_POS_UP),
    .i_dn(I_POS_DN),
    .o_cnt(pos_cnt)
  );

  // last count direction steers the index counter
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      dir_dn_q <= 1'b0;
    end else if (I_POS_UP != I_POS_DN) begin
      dir_dn_q <= I_POS_DN;
    end
  end

  // index counter load path, same split-word scheme as position
  always_comb begin
    idx_load = wr_acc && (I_PADDR == OFS_IDX_L || I_PADDR == OFS_IDX_H);
    idx_load_val = (I_PADDR == OFS_IDX_L) ? {idx_hold_q, wlo}
                                          : put_half(idx_cnt, 1'b1, wlo);
  end

  eqc_cnt32 u_idx (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_load(idx_load),
    .i_load_val(idx_load_val),
    .i_up(evt_idx & ~dir_dn_q),
    .i_dn(evt_idx & dir_dn_q),
    .o_cnt(idx_cnt)
  );

  // interval timer: low write takes the high half from the interval hold
  always_comb begin
    tmr_load = wr_acc && (I_PADDR == OFS_TMR_L || I_PADDR == OFS_TMR_H);
    tmr_load_val = (I_PADDR == OFS_TMR_L) ? {thld_q[31:16], wlo}
                                          : put_half(tmr_cnt, 1'b1, wlo);
  end

  eqc_cnt32 u_tmr (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_load(tmr_load),
    .i_load_val(tmr_load_val),
    .i_up(I_TMR_TICK),
    .i_dn(1'b0),
    .o_cnt(tmr_cnt)
  );

  // hold registers: a low-word read snapshots the high word for a coherent pair
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pos_hold_q <= WORD_RST;
      idx_hold_q <= WORD_RST;
      thld_q <= DWORD_RST;
    end else begin
      if (rd_set && I_PADDR == OFS_POS_L) begin
        pos_hold_q <= pos_cnt[31:16];
      end else if (wr_acc && I_PADDR == OFS_POS_HLD) begin
        pos_hold_q <= wlo;
      end
      if (rd_set && I_PADDR == OFS_IDX_L) begin
        idx_hold_q <= idx_cnt[31:16];
      end else if (wr_acc && I_PADDR == OFS_IDX_HLD) begin
        idx_hold_q <= wlo;
      end
      if (rd_set && I_PADDR == OFS_TMR_L) begin
        thld_q <= tmr_cnt;
      end else if (wr_acc && (I_PADDR == OFS_THLD_H || I_PADDR == OFS_THLD_L)) begin
        thld_q <= put_half(thld_q, I_PADDR == OFS_THLD_H, wlo);
      end
    end
  end

  // velocity counter, single word, software write wins over counting
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      vel_q <= WORD_RST;
    end else if (wr_acc && I_PADDR == OFS_VEL) begin
      vel_q <= wlo;
    end else if (I_POS_UP && !I_POS_DN) begin
      vel_q <= vel_q + 16'h0001;
    end else if (I_POS_DN && !I_POS_UP) begin
      vel_q <= vel_q - 16'h0001;
    end
  end

  // compare values and init/capture; a software write beats a home capture
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ic_q <= DWORD_RST;
      le_q <= DWORD_RST;
      ge_q <= DWORD_RST;
    end else begin
      if (wr_acc && (I_PADDR == OFS_IC_H || I_PADDR == OFS_IC_L)) begin
        ic_q <= put_half(ic_q, I_PADDR == OFS_IC_H, wlo);
      end else if (cap_en_q && evt_home) begin
        ic_q <= pos_cnt;
      end
      if (wr_acc && (I_PADDR == OFS_LE_H || I_PADDR == OFS_LE_L)) begin
        le_q <= put_half(le_q, I_PADDR == OFS_LE_H, wlo);
      end
      if (wr_acc && (I_PADDR == OFS_GE_H || I_PADDR == OFS_GE_L)) begin
        ge_q <= put_half(ge_q, I_PADDR == OFS_GE_H, wlo);
      end
    end
  end

  // registered compare results; unsigned compare of the live count
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      le_q_out <= 1'b0;
      ge_q_out <= 1'b0;
    end else begin
      le_q_out <= (pos_cnt <= le_q);
      ge_q_out <= (pos_cnt >= ge_q);
    end
  end
  assign O_LE_MATCH = le_q_out;
  assign O_GE_MATCH = ge_q_out;

  // interrupt enables, reachable through status and enable offsets alike
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      en_idx_q <= 1'b0;
      en_re_q <= 1'b0;
    end else if (wr_acc && (I_PADDR == OFS_STATUS || I_PADDR == OFS_IRQ_EN)) begin
      en_idx_q <= I_PWDATA[EN_IDX_BIT];
      en_re_q <= I_PWDATA[EN_RE_BIT];
    end
  end

  // sticky flags: set wins over read-clear and write-one-clear in the same cycle
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st_idx_q <= 1'b0;
      st_re_q <= 1'b0;
    end else begin
      if (evt_idx) begin
        st_idx_q <= 1'b1;
      end else if ((rd_set && I_PADDR == OFS_STATUS) ||
                   (wr_acc && I_PADDR == OFS_IRQ_CLR && I_PWDATA[ST_IDX_BIT])) begin
        st_idx_q <= 1'b0;
      end
      if (init_act && init_load) begin
        st_re_q <= 1'b1;
      end else if (wr_acc && I_PADDR == OFS_IRQ_CLR && I_PWDATA[ST_RE_BIT]) begin
        st_re_q <= 1'b0;
      end
    end
  end

  // level interrupt: any enabled flag
  assign O_IRQ = (st_idx_q & en_idx_q) | (st_re_q & en_re_q);

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  idx_flag_set_a: assert property (evt_idx |=> st_idx_q)
    else $error("index event did not set the index flag");
  idx_flag_quiet_a: assert property (!st_idx_q && !evt_idx |=> !st_idx_q)
    else $error("index flag set without an index event");
  irq_gate_a: assert property (!en_idx_q && !(st_re_q && en_re_q) |-> !O_IRQ)
    else $error("interrupt raised while index enable is off");
  irq_raise_a: assert property (st_idx_q && en_idx_q |-> O_IRQ)
    else $error("enabled index flag did not raise the interrupt");
  reinit_mode_a: assert property ($rose(st_re_q) |->
      ($past(mode_q) == PIM_FIRST_IDX_LOAD || $past(mode_q) == PIM_SECOND_IDX_LOAD))
    else $error("reinit flag set outside modes 011 and 100");
  pos_atomic_a: assert property (wr_acc && I_PADDR == OFS_POS_L
      |=> pos_cnt == {$past(pos_hold_q), $past(I_PWDATA[15:0])})
    else $error("position low write did not load the high word from hold");
  pos_snap_a: assert property (rd_set && I_PADDR == OFS_POS_L
      |=> pos_hold_q == $past(pos_cnt[31:16]) && prdata_q[15:0] == $past(pos_cnt[15:0]))
    else $error("position low read did not snapshot the high word");
  idx_atomic_a: assert property (wr_acc && I_PADDR == OFS_IDX_L
      |=> idx_cnt == {$past(idx_hold_q), $past(I_PWDATA[15:0])})
    else $error("index low write not atomic");
  vel_write_a: assert property (wr_acc && I_PADDR == OFS_VEL
      |=> vel_q == $past(I_PWDATA[15:0]))
    else $error("velocity write lost");
  ic_write_a: assert property (wr_acc && I_PADDR == OFS_IC_H
      |=> ic_q[31:16] == $past(I_PWDATA[15:0]) && ic_q[15:0] == $past(ic_q[15:0]))
    else $error("init/capture high write wrong");
  cmp_write_a: assert property (wr_acc && I_PADDR == OFS_LE_L
      |=> le_q[15:0] == $past(I_PWDATA[15:0]) ##1 O_LE_MATCH == ($past(pos_cnt) <= le_q))
    else $error("less-or-equal compare write or match wrong");
  ge_write_a: assert property (wr_acc && I_PADDR == OFS_GE_H
      |=> ge_q[31:16] == $past(I_PWDATA[15:0]))
    else $error("greater-or-equal compare write wrong");
  tmr_atomic_a: assert property (wr_acc && I_PADDR == OFS_TMR_L
      |=> tmr_cnt == {$past(thld_q[31:16]), $past(I_PWDATA[15:0])})
    else $error("interval timer low write not atomic");
  read_clear_a: assert property (rd_set && I_PADDR == OFS_STATUS && !evt_idx
      |=> !st_idx_q ##1 (st_idx_q == $past(evt_idx)))
    else $error("status read did not clear the index flag");

  cov_irq_c: cover property (evt_idx && en_idx_q ##1 O_IRQ);
  cov_reinit_c: cover property (mode_q == PIM_SECOND_IDX_LOAD && $rose(st_re_q));
  cov_race_c: cover property (evt_idx && rd_set && I_PADDR == OFS_STATUS);
endmodule : eqc_regs

/* File: tb/eqc_enc_model.sv */
// encoder far side: count pulses, index and home levels, timer ticks
// assumes one clock; outputs change only just after a rising edge
`timescale 1ns/1ps
module eqc_enc_model (
  input wire logic i_clk,
  output logic o_up,
  output logic o_dn,
  output logic o_index,
  output logic o_home,
  output logic o_tick
);
  // quiet levels from time zero
  initial begin
    {o_up, o_dn, o_index, o_home, o_tick} = 5'h00;
  end
  // hold a pattern for n cycles, then drop it and idle one more cycle
  // the idle cycle lets index and home fall before the next edge
  task automatic strobe(input int n, input logic [4:0] pat);
    repeat (n) begin
      @(posedge i_clk);
      {o_up, o_dn, o_index, o_home, o_tick} <= pat;
    end
    @(posedge i_clk);
    {o_up, o_dn, o_index, o_home, o_tick} <= 5'h00;
    @(posedge i_clk);
  endtask : strobe
endmodule : eqc_enc_model

/* File: tb/tb_top.sv */
// testbench: apb master, encoder model and reference counters
// assumes eqc_pkg offsets; the slave answer is waited for until the watchdog ends the run
`timescale 1ns/1ps
module tb_top;
  import eqc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  eqc_addr_t paddr;
  logic [31:0] pwdata, prdata, r, pos_m, idx_m, tmr_m, pm, icv;
  logic up, dn, idx_pin, home, tick, irq, le_match, ge_match;
  logic [15:0] vel_m, ph, ih, th, tl;
  logic [15:0] cv [6];
  int err_total;
  int checks_done;

  eqc_regs i_eqc_regs (
    .I_CLK(clk), .I_RST_N(rst_n), .I_PADDR(paddr), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_POS_UP(up), .I_POS_DN(dn), .I_INDEX(idx_pin), .I_HOME(home),
    .I_TMR_TICK(tick), .O_IRQ(irq), .O_LE_MATCH(le_match), .O_GE_MATCH(ge_match)
  );
  eqc_enc_model i_eqc_enc_model (
    .i_clk(clk), .o_up(up), .o_dn(dn), .o_index(idx_pin), .o_home(home), .o_tick(tick)
  );

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(input eqc_addr_t a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no assumed wait count; only the watchdog bounds this wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input eqc_addr_t a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  // read a word and compare; upper half always zero
  task automatic rdc(input eqc_addr_t a, input logic [15:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(r, {16'h0000, exp});
  endtask : rdc

  task automatic final_report();
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report();
  end

  // main sequence
  initial begin
    void'($urandom(33986));
    {rst_n, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // every register zero after reset
    for (int a = 0; a <= 'h50; a += 4) begin
      rdc(eqc_addr_t'(a), 16'h0000);
    end
    // init/capture and compare halves, each written alone
    for (int k = 0; k < 6; k++) begin
      cv[k] = 16'($urandom);
      wr(eqc_addr_t'(OFS_IC_H + 4 * k), {16'h0000, cv[k]});
      rdc(eqc_addr_t'(OFS_IC_H + 4 * k), cv[k]);
    end
    // position and index loaded through hold, position low word 0xFFFF for a carry, index low word 0x0000 for a borrow
    ph = 16'($urandom);
    ih = 16'($urandom);
    vel_m = 16'($urandom);
    wr(OFS_POS_HLD, {16'h0000, ph});
    wr(OFS_POS_L, 32'h0000_FFFF);
    wr(OFS_VEL, {16'h0000, vel_m});
    wr(OFS_IDX_HLD, {16'h0000, ih});
    wr(OFS_IDX_L, 32'h0000_0000);
    rdc(OFS_POS_H, ph);
    pos_m = {ph, 16'hFFFF} + 32'd2;
    idx_m = {ih, 16'h0000} - 32'd1;
    vel_m = vel_m + 16'd2;
    i_eqc_enc_model.strobe(3, 5'h10);
    i_eqc_enc_model.strobe(1, 5'h08);
    i_eqc_enc_model.strobe(1, 5'h04);
    rdc(OFS_POS_L, pos_m[15:0]);
    rdc(OFS_POS_HLD, pos_m[31:16]);
    rdc(OFS_VEL, vel_m);
    rdc(OFS_IDX_L, idx_m[15:0]);
    rdc(OFS_IDX_HLD, idx_m[31:16]);
    chk(32'(le_match), 32'(pos_m <= {cv[2], cv[3]}));
    chk(32'(ge_match), 32'(pos_m >= {cv[4], cv[5]}));
    rdc(OFS_STATUS, 16'h0002);
    rdc(OFS_STATUS, 16'h0000);
    // interval timer written through its hold, then ticked
    th = 16'($urandom);
    tl = 16'($urandom);
    wr(OFS_THLD_H, {16'h0000, th});
    wr(OFS_TMR_L, {16'h0000, tl});
    tmr_m = {th, tl} + 32'd5;
    i_eqc_enc_model.strobe(5, 5'h01);
    rdc(OFS_TMR_L, tmr_m[15:0]);
    rdc(OFS_THLD_H, tmr_m[31:16]);
    rdc(OFS_THLD_L, tmr_m[15:0]);
    rdc(OFS_TMR_H, tmr_m[31:16]);
    // index interrupt enabled, then masked
    wr(OFS_IRQ_EN, 32'h0000_0001);
    i_eqc_enc_model.strobe(1, 5'h04);
    chk(32'(irq), 32'h0000_0001);
    rdc(OFS_STATUS, 16'h0003);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_EN, 32'h0000_0000);
    i_eqc_enc_model.strobe(1, 5'h04);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_CLR, 32'h0000_0002);
    rdc(OFS_STATUS, 16'h0000);
    // unaligned write ignored, unmapped read gives zero
    apb(8'h13, 1'b1, 32'h0000_FFFF);
    chk(32'(e), 32'h0000_0001);
    apb(8'h54, 1'b0, 32'h0000_0000);
    chk({31'h0, e} | r, 32'h0000_0001);
    rdc(OFS_POS_H, pos_m[31:16]);
    // reinit interrupt enabled through the status alias, read back at the enable offset
    wr(OFS_STATUS, 32'h0000_0040);
    rdc(OFS_IRQ_EN, 16'h0040);
    // every init mode: home, then two index events
    for (int m = 0; m < 6; m++) begin
      pm = $urandom;
      icv = $urandom;
      wr(OFS_CTRL, 32'(m));
      wr(OFS_IC_H, {16'h0000, icv[31:16]});
      wr(OFS_IC_L, {16'h0000, icv[15:0]});
      wr(OFS_POS_HLD, {16'h0000, pm[31:16]});
      wr(OFS_POS_L, {16'h0000, pm[15:0]});
      wr(OFS_IRQ_CLR, 32'h0000_0082);
      i_eqc_enc_model.strobe(1, 5'h02);
      i_eqc_enc_model.strobe(1, 5'h04);
      i_eqc_enc_model.strobe(1, 5'h04);
      pos_m = (m == 1 || m == 2) ? 32'h0000_0000 : ((m == 3 || m == 4) ? icv : pm);
      chk(32'(irq), 32'(m == 3 || m == 4));
      rdc(OFS_STATUS, (m == 3 || m == 4) ? 16'h00C2 : 16'h0042);
      rdc(OFS_POS_L, pos_m[15:0]);
      rdc(OFS_POS_HLD, pos_m[31:16]);
    end
    // home capture copies position into init/capture
    wr(OFS_CTRL, 32'h0000_0008);
    i_eqc_enc_model.strobe(1, 5'h02);
    rdc(OFS_IC_L, pos_m[15:0]);
    rdc(OFS_IC_H, pos_m[31:16]);
    final_report();
  end
endmodule : tb_top
